// file: rtl/pmrc_power_mode_reset_control.sv
// Power mode and reset controller: mode machine, buttons, reset pulses
//
// What this block does
// - Soft reset drives reset output low 10ms
// - Soft reset keeps or restores registers by select
// - Hard reset runs the full power-on sequence
// - Cold boot with select 0 enters seal
// - Cold boot with select 1 enters recovery
// - Host command moves ON to off/seal/recovery
// - Qualified button event enters off or recovery
// - Key press or charger wakes from off/seal
// - ON keeps system node and regulators on, aux regulator controllable
// - OFF keeps only always-on auxiliary regulator
// - SEAL turns everything off
// - Triggers from buttons, commands, internal conditions
// - Config 0000: key active high, B soft reset
// - Config 0001: key active low, B soft reset
// - Config 0010: A edge hard resets after 200ms
`timescale 1ns/10ps
`default_nettype none

module pmrc_power_mode_reset_control #(
   parameter logic [pmrc_pkg::CNT_W-1:0] SRST_CYC = pmrc_pkg::SOFT_RST_CYC,
   parameter logic [pmrc_pkg::CNT_W-1:0] DEB_CYC = pmrc_pkg::DEBOUNCE_CYC,
   parameter logic [pmrc_pkg::CNT_W-1:0] AON_CYC = pmrc_pkg::AON_DELAY_CYC
) (
   // Clock and reset
   input wire logic MCLK,
   input wire logic RST,
   // Button pins and supply detection
   input wire logic POWER_BUTTON_INPUT_A,
   input wire logic POWER_BUTTON_INPUT_B,
   input wire logic CHARGER_SUPPLY_INPUT,
   input wire logic INTERNAL_OFF_REQ,
   // Configuration
   input wire logic [3:0] BUTTON_BEHAVIOR_CFG,
   input wire logic COLD_BOOT_RECOVERY_SEL,
   input wire logic SOFT_RESET_RESTORE_SEL,
   input wire logic AUX_REGULATOR_SEQUENCE_SEL,
   input wire logic AUX_REGULATOR_REQ,
   // Power command write from the host register file
   input wire logic [7:0] POWER_COMMAND_REG,
   input wire logic POWER_COMMAND_WR,
   // Power and reset outputs
   output var logic SYS_RESET_N,
   output var logic SYSTEM_POWER_NODE_EN,
   output var logic REGULATORS_EN,
   output var logic AUX_LINEAR_REGULATOR_EN,
   output var logic REGISTER_RESTORE,
   output var logic POR_START,
   output var logic [4:0] POWER_MODE
);

   // -----------------------------------------------------------------------
   // State
   // -----------------------------------------------------------------------
   typedef struct packed {
      logic [1:0] sync1;
      logic [1:0] sync2;
      logic [1:0] prev;
      logic [1:0] db_lvl;
      logic [1:0][pmrc_pkg::CNT_W-1:0] db_cnt;
      pmrc_pkg::pmrc_mode_e mode;
      logic [pmrc_pkg::CNT_W-1:0] rst_cnt;
      logic rst_n;
      logic restore;
      logic por;
      logic [pmrc_pkg::CNT_W-1:0] aon_cnt;
      logic aon_busy;
      logic aon_hard;
      logic aux_en;
      logic sys_en;
   } pmrc_state_s;

   pmrc_state_s q_reg;
   pmrc_state_s q_next;
   logic a_press;
   logic b_press;
   logic a_rise;
   logic b_rise;
   logic start_srst;

   // Button setting uses pin A as the key input
   function automatic logic is_key_cfg(input logic [3:0] cfg);
      return (cfg == pmrc_pkg::CFG_KEY_HIGH) || (cfg == pmrc_pkg::CFG_KEY_LOW);
   endfunction

   // Press edge of the key in its configured polarity
   function automatic logic press_edge(input logic [3:0] cfg,
                                       input logic now_lvl,
                                       input logic old_lvl);
      if (!is_key_cfg(cfg)) begin
         return 1'b0;
      end else if (cfg == pmrc_pkg::CFG_KEY_HIGH) begin
         return now_lvl & ~old_lvl;
      end else begin
         return ~now_lvl & old_lvl;
      end
   endfunction

   // -----------------------------------------------------------------------
   // Next state
   // -----------------------------------------------------------------------
   always_comb begin
      q_next = q_reg;
      start_srst = 1'b0;
      // Two sync flops per pin plus a delayed copy; only sync2 and prev feed logic
      q_next.sync1 = {POWER_BUTTON_INPUT_B, POWER_BUTTON_INPUT_A};
      q_next.sync2 = q_reg.sync1;
      q_next.prev = q_reg.sync2;
      q_next.por = 1'b0;
      q_next.restore = 1'b0;

      // Debounce: level must hold for the full window before it counts
      for (int i = 0; i < 2; i++) begin
         if (q_reg.sync2[i] == q_reg.db_lvl[i]) begin
            q_next.db_cnt[i] = '0;
         end else if (q_reg.db_cnt[i] == DEB_CYC - pmrc_pkg::CNT_ONE) begin
            q_next.db_cnt[i] = '0;
            q_next.db_lvl[i] = q_reg.sync2[i];
         end else begin
            q_next.db_cnt[i] = q_reg.db_cnt[i] + pmrc_pkg::CNT_ONE;
         end
      end

      // Qualified button events
      a_press = press_edge(BUTTON_BEHAVIOR_CFG, q_next.db_lvl[0],
                           q_reg.db_lvl[0]);
      b_press = is_key_cfg(BUTTON_BEHAVIOR_CFG) & q_reg.db_lvl[1] &
                ~q_next.db_lvl[1];
      a_rise = (BUTTON_BEHAVIOR_CFG == pmrc_pkg::CFG_ALWAYS_ON) &
               q_reg.sync2[0] & ~q_reg.prev[0];
      b_rise = (BUTTON_BEHAVIOR_CFG == pmrc_pkg::CFG_ALWAYS_ON) &
               q_reg.sync2[1] & ~q_reg.prev[1];

      // Mode machine
      case (q_reg.mode)
         pmrc_pkg::ST_BOOT: begin
            // Straps are sampled here, after reset release
            if (CHARGER_SUPPLY_INPUT) begin
               q_next.mode = pmrc_pkg::ST_ON;
            end else if (COLD_BOOT_RECOVERY_SEL) begin
               q_next.mode = pmrc_pkg::ST_RECOV;
            end else begin
               q_next.mode = pmrc_pkg::ST_SEAL;
            end
         end
         pmrc_pkg::ST_ON: begin
            // Delay timer for always-on button edges
            if (!q_reg.aon_busy && (a_rise || b_rise)) begin
               q_next.aon_busy = 1'b1;
               q_next.aon_cnt = '0;
               q_next.aon_hard = a_rise;
            end else if (q_reg.aon_busy) begin
               q_next.aon_cnt = q_reg.aon_cnt + pmrc_pkg::CNT_ONE;
            end
            // A write is a one-cycle strobe, so it acts exactly once
            if (POWER_COMMAND_WR &&
                POWER_COMMAND_REG == pmrc_pkg::CMD_GO_OFF) begin
               q_next.mode = pmrc_pkg::ST_OFF;
            end else if (POWER_COMMAND_WR &&
                         POWER_COMMAND_REG == pmrc_pkg::CMD_GO_SEAL) begin
               q_next.mode = pmrc_pkg::ST_SEAL;
            end else if (POWER_COMMAND_WR &&
                         POWER_COMMAND_REG == pmrc_pkg::CMD_GO_RECOVERY) begin
               q_next.mode = pmrc_pkg::ST_RECOV;
            end else if (q_reg.aon_busy &&
                         q_reg.aon_cnt == AON_CYC - pmrc_pkg::CNT_ONE) begin
               q_next.aon_busy = 1'b0;
               if (q_reg.aon_hard) begin
                  q_next.por = 1'b1;
                  q_next.mode = pmrc_pkg::ST_BOOT;
               end else begin
                  start_srst = 1'b1;
               end
            end else if (a_press) begin
               q_next.mode = COLD_BOOT_RECOVERY_SEL ? pmrc_pkg::ST_RECOV
                                                    : pmrc_pkg::ST_OFF;
            end else if (INTERNAL_OFF_REQ) begin
               q_next.mode = pmrc_pkg::ST_OFF;
            end else if (b_press) begin
               start_srst = 1'b1;
            end
         end
         pmrc_pkg::ST_OFF, pmrc_pkg::ST_SEAL: begin
            if (CHARGER_SUPPLY_INPUT || a_press) begin
               q_next.mode = pmrc_pkg::ST_ON;
            end
         end
         pmrc_pkg::ST_RECOV: begin
            if (CHARGER_SUPPLY_INPUT) begin
               q_next.mode = pmrc_pkg::ST_ON;
            end
         end
         default: begin
            q_next.mode = pmrc_pkg::ST_BOOT;
         end
      endcase
      // A pending delayed reset dies when the device leaves ON
      if (q_next.mode != pmrc_pkg::ST_ON) begin
         q_next.aon_busy = 1'b0;
      end

      // Soft reset pulse; a request during a pulse is absorbed
      if (q_reg.rst_cnt != '0) begin
         q_next.rst_cnt = q_reg.rst_cnt - pmrc_pkg::CNT_ONE;
      end else if (start_srst) begin
         q_next.rst_cnt = SRST_CYC;
         q_next.restore = SOFT_RESET_RESTORE_SEL;
      end
      q_next.rst_n = (q_next.rst_cnt == '0);

      // Supply enables follow the next mode
      q_next.sys_en = (q_next.mode == pmrc_pkg::ST_ON);
      if (q_next.mode == pmrc_pkg::ST_ON) begin
         q_next.aux_en = AUX_REGULATOR_REQ | AUX_REGULATOR_SEQUENCE_SEL;
      end else if (q_next.mode == pmrc_pkg::ST_OFF) begin
         q_next.aux_en = q_reg.aux_en | ((q_reg.mode == pmrc_pkg::ST_ON) &
                         AUX_REGULATOR_SEQUENCE_SEL);
      end else begin
         q_next.aux_en = 1'b0;
      end
   end

   // -----------------------------------------------------------------------
   // Registers
   // -----------------------------------------------------------------------
   // Reset loads constants only; straps wait for the boot state
   always_ff @(posedge MCLK or posedge RST) begin
      if (RST) begin
         q_reg <= '0;
         q_reg.mode <= pmrc_pkg::ST_BOOT;
         q_reg.rst_n <= 1'b1;
         // Pin B idles high; a zero here would fake an edge after reset
         q_reg.sync1[1] <= 1'b1;
         q_reg.sync2[1] <= 1'b1;
         q_reg.prev[1] <= 1'b1;
         q_reg.db_lvl[1] <= 1'b1;
      end else begin
         q_reg <= q_next;
      end
   end

   // Outputs straight from flops
   assign SYS_RESET_N = q_reg.rst_n;
   assign SYSTEM_POWER_NODE_EN = q_reg.sys_en;
   assign REGULATORS_EN = q_reg.sys_en;
   assign AUX_LINEAR_REGULATOR_EN = q_reg.aux_en;
   assign REGISTER_RESTORE = q_reg.restore;
   assign POR_START = q_reg.por;
   assign POWER_MODE = q_reg.mode;

   // -----------------------------------------------------------------------
   // Assertions
   // -----------------------------------------------------------------------
   logic [pmrc_pkg::CNT_W-1:0] low_cnt_reg;

   // Length of the current low phase of the reset output
   always_ff @(posedge MCLK or posedge RST) begin
      if (RST) begin
         low_cnt_reg <= '0;
      end else if (q_reg.rst_n) begin
         low_cnt_reg <= '0;
      end else begin
         low_cnt_reg <= low_cnt_reg + pmrc_pkg::CNT_ONE;
      end
   end

   default clocking cb @(posedge MCLK); endclocking
   default disable iff (RST);

   a_srst_pulse_len: assert property (
      $rose(SYS_RESET_N) |-> low_cnt_reg == SRST_CYC)
      else $error("soft reset pulse length wrong");
   a_restore_choice: assert property (
      $fell(SYS_RESET_N) |-> REGISTER_RESTORE == $past(SOFT_RESET_RESTORE_SEL))
      else $error("register restore does not follow select");
   a_por_from_on: assert property (
      POR_START |-> POWER_MODE == pmrc_pkg::ST_BOOT &&
                    $past(POWER_MODE) == pmrc_pkg::ST_ON)
      else $error("hard reset not a boot from ON");
   a_cold_to_seal: assert property (
      POWER_MODE == pmrc_pkg::ST_BOOT && !CHARGER_SUPPLY_INPUT &&
      !COLD_BOOT_RECOVERY_SEL |=> POWER_MODE == pmrc_pkg::ST_SEAL)
      else $error("cold boot did not seal");
   a_cold_to_recov: assert property (
      POWER_MODE == pmrc_pkg::ST_BOOT && !CHARGER_SUPPLY_INPUT &&
      COLD_BOOT_RECOVERY_SEL |=> POWER_MODE == pmrc_pkg::ST_RECOV)
      else $error("cold boot did not enter recovery");
   a_cmd_off: assert property (
      POWER_MODE == pmrc_pkg::ST_ON && POWER_COMMAND_WR &&
      POWER_COMMAND_REG == pmrc_pkg::CMD_GO_OFF
      |=> POWER_MODE == pmrc_pkg::ST_OFF && !SYSTEM_POWER_NODE_EN &&
      !REGULATORS_EN)
      else $error("off command not obeyed");
   a_charger_wake: assert property (
      (POWER_MODE == pmrc_pkg::ST_OFF || POWER_MODE == pmrc_pkg::ST_SEAL) &&
      CHARGER_SUPPLY_INPUT |=> POWER_MODE == pmrc_pkg::ST_ON &&
      SYSTEM_POWER_NODE_EN)
      else $error("charger did not wake device");
   a_sys_node_on: assert property (
      SYSTEM_POWER_NODE_EN == (POWER_MODE == pmrc_pkg::ST_ON))
      else $error("system node does not match ON mode");
   a_off_aux_keep: assert property (
      POWER_MODE == pmrc_pkg::ST_OFF && $past(POWER_MODE) == pmrc_pkg::ST_ON
      |-> AUX_LINEAR_REGULATOR_EN == ($past(AUX_LINEAR_REGULATOR_EN) |
                                      $past(AUX_REGULATOR_SEQUENCE_SEL)))
      else $error("auxiliary regulator wrong on entering OFF");
   a_seal_all_off: assert property (
      POWER_MODE == pmrc_pkg::ST_SEAL |-> !AUX_LINEAR_REGULATOR_EN &&
      !REGULATORS_EN && !SYSTEM_POWER_NODE_EN)
      else $error("supply left on in seal");
   a_aon_no_off: assert property (
      BUTTON_BEHAVIOR_CFG == pmrc_pkg::CFG_ALWAYS_ON &&
      POWER_MODE == pmrc_pkg::ST_ON && !POWER_COMMAND_WR && !INTERNAL_OFF_REQ
      |=> POWER_MODE != pmrc_pkg::ST_OFF)
      else $error("always-on mode left ON without command");

   c_cmd_off: cover property (
      POWER_MODE == pmrc_pkg::ST_ON ##1 POWER_MODE == pmrc_pkg::ST_OFF);
   c_soft_reset: cover property ($rose(SYS_RESET_N));
   c_hard_reset: cover property (POR_START);
   c_seal_wake: cover property (
      POWER_MODE == pmrc_pkg::ST_SEAL ##1 POWER_MODE == pmrc_pkg::ST_ON);

endmodule // pmrc_power_mode_reset_control

`default_nettype wire

// file: rtl/pmrc_pkg.sv
// Constants, codes and mode encoding for the power mode and reset control
package pmrc_pkg;
   // --------------------------------------------------------------------
   // Timing
   // --------------------------------------------------------------------
   localparam int CLK_MHZ = 100;
   localparam int US_PER_MS = 1000;
   localparam int SOFT_RST_MS = 10;
   localparam int DEBOUNCE_MS = 10;
   localparam int AON_DELAY_MS = 200;
   localparam int CNT_W = 25;
   localparam logic [CNT_W-1:0] SOFT_RST_CYC =
      CNT_W'(SOFT_RST_MS * US_PER_MS * CLK_MHZ);
   localparam logic [CNT_W-1:0] DEBOUNCE_CYC =
      CNT_W'(DEBOUNCE_MS * US_PER_MS * CLK_MHZ);
   localparam logic [CNT_W-1:0] AON_DELAY_CYC =
      CNT_W'(AON_DELAY_MS * US_PER_MS * CLK_MHZ);
   localparam logic [CNT_W-1:0] CNT_ONE = 25'h0000001;

   // --------------------------------------------------------------------
   // Power command codes and button behaviour settings
   // --------------------------------------------------------------------
   localparam logic [7:0] CMD_GO_OFF = 8'h01;
   localparam logic [7:0] CMD_GO_SEAL = 8'h02;
   localparam logic [7:0] CMD_GO_RECOVERY = 8'h03;
   localparam logic [3:0] CFG_KEY_HIGH = 4'h0;
   localparam logic [3:0] CFG_KEY_LOW = 4'h1;
   localparam logic [3:0] CFG_ALWAYS_ON = 4'h2;

   // --------------------------------------------------------------------
   // Power modes, one-hot
   // --------------------------------------------------------------------
   typedef enum logic [4:0] {
      ST_BOOT = 5'h01,
      ST_ON = 5'h02,
      ST_OFF = 5'h04,
      ST_SEAL = 5'h08,
      ST_RECOV = 5'h10
   } pmrc_mode_e;
endpackage

// file: verif/pmrc_host_model.sv
// Host and push-button model on the far side of the power controller
`timescale 1ns/10ps
`default_nettype none

module pmrc_host_model (
   // Clock
   input wire logic mclk,
   // Button pins
   output var logic btn_a,
   output var logic btn_b,
   // Power command write
   output var logic [7:0] cmd_code,
   output var logic cmd_wr
);
   // ----------------------------------------------------------------
   // Pin and command drivers
   // ----------------------------------------------------------------
   // Buttons start released for the key-high setting
   initial begin
      btn_a = 1'b0;
      btn_b = 1'b1;
      cmd_code = 8'hff;
      cmd_wr = 1'b0;
   end

   // Pins move at an edge; debounce is the design's job
   task automatic set_pins(input logic a, input logic b);
      @(posedge mclk);
      btn_a <= a;
      btn_b <= b;
   endtask

   // Strobe lasts exactly one cycle so each write acts once
   task automatic write_cmd(input logic [7:0] code);
      @(posedge mclk);
      cmd_code <= code;
      cmd_wr <= 1'b1;
      @(posedge mclk);
      cmd_wr <= 1'b0;
      cmd_code <= ~code; // Stale code must not be reused
   endtask
endmodule // pmrc_host_model
`default_nettype wire

// file: verif/pmrc_power_mode_reset_control_tb_top.sv
// Self-checking bench for the power mode and reset controller
`timescale 1ns/10ps
`default_nettype none

module pmrc_power_mode_reset_control_tb_top;
   // ----------------------------------------------------------------
   // Shortened counts and bench signals
   // ----------------------------------------------------------------
   localparam logic [24:0] SRST = 25'h0000014;
   localparam logic [24:0] DEB = 25'h0000008;
   localparam logic [24:0] ALWAYS_ON_BEHAVIOR = 25'h0000028;
   logic mclk, rst, chg, boot_sel, restore_sel, seq_sel, int_off, aux_req;
   logic [3:0] cfg;
   logic btn_a, btn_b, cmd_wr, rst_n, sys_en, reg_en, aux_en, restore, por;
   logic [7:0] cmd_code;
   logic [4:0] mode;
   logic [7:0] codes [3];
   logic [4:0] modes [3];
   int mismatches, checks, n;

   // Clock, 10 ns period
   initial mclk = 1'b0;
   always #5 mclk = ~mclk;

   // Far side: buttons and host command writes
   pmrc_host_model host (.mclk(mclk), .btn_a(btn_a), .btn_b(btn_b),
      .cmd_code(cmd_code), .cmd_wr(cmd_wr));

   pmrc_power_mode_reset_control #(.SRST_CYC(SRST), .DEB_CYC(DEB),
      .AON_CYC(ALWAYS_ON_BEHAVIOR)) dut (.MCLK(mclk), .RST(rst),
      .POWER_BUTTON_INPUT_A(btn_a), .POWER_BUTTON_INPUT_B(btn_b),
      .CHARGER_SUPPLY_INPUT(chg), .INTERNAL_OFF_REQ(int_off),
      .BUTTON_BEHAVIOR_CFG(cfg), .COLD_BOOT_RECOVERY_SEL(boot_sel),
      .SOFT_RESET_RESTORE_SEL(restore_sel),
      .AUX_REGULATOR_SEQUENCE_SEL(seq_sel), .AUX_REGULATOR_REQ(aux_req),
      .POWER_COMMAND_REG(cmd_code), .POWER_COMMAND_WR(cmd_wr),
      .SYS_RESET_N(rst_n), .SYSTEM_POWER_NODE_EN(sys_en),
      .REGULATORS_EN(reg_en), .AUX_LINEAR_REGULATOR_EN(aux_en),
      .REGISTER_RESTORE(restore), .POR_START(por), .POWER_MODE(mode));

   // ----------------------------------------------------------------
   // Shared tasks
   // ----------------------------------------------------------------
   task automatic summarize();
      $display("checks %0d mismatches %0d", checks, mismatches);
      if (mismatches == 0 && checks > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask

   task automatic check(input string nm, input logic [7:0] seen,
                        input logic [7:0] exp);
      checks++;
      if (seen !== exp) begin
         mismatches++;
         $display("[ERR] %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   // One settled cycle of a bounded wait; a hang ends the run
   task automatic step();
      @(posedge mclk);
      #1;
      n++;
      if (n > 400) begin
         mismatches++;
         $display("[ERR] wait limit expected 400 seen %0d", n);
         summarize();
      end
   endtask

   task automatic wait_mode(input logic [4:0] exp);
      // Let the edge settle before the first look
      #1;
      n = 0;
      while (mode !== exp) step();
      check("mode", {3'h0, mode}, {3'h0, exp});
   endtask

   // Charger pulse wakes the device, then goes away
   task automatic wake();
      @(posedge mclk) chg <= 1'b1;
      wait_mode(pmrc_pkg::ST_ON);
      check("system node", {7'h0, sys_en}, 8'h01);
      check("regulators", {7'h0, reg_en}, 8'h01);
      @(posedge mclk) chg <= 1'b0;
   endtask

   // ----------------------------------------------------------------
   // Main sequence
   // ----------------------------------------------------------------
   initial begin
      codes = '{pmrc_pkg::CMD_GO_OFF, pmrc_pkg::CMD_GO_SEAL,
                pmrc_pkg::CMD_GO_RECOVERY};
      modes = '{pmrc_pkg::ST_OFF, pmrc_pkg::ST_SEAL, pmrc_pkg::ST_RECOV};
      {rst, chg, boot_sel, restore_sel, seq_sel, int_off} = 6'b100110;
      cfg = pmrc_pkg::CFG_KEY_HIGH;
      aux_req = 1'b0;
      mismatches = 0;
      checks = 0;
      repeat (8) @(posedge mclk);
      rst <= 1'b0;
      // Cold boot without charger, select 0
      wait_mode(pmrc_pkg::ST_SEAL);
      check("seal outputs", {5'h0, sys_en, reg_en, aux_en}, 8'h00);
      wake();
      // Undefined codes change nothing
      host.write_cmd(8'h07);
      host.write_cmd(8'h00);
      repeat (3) @(posedge mclk);
      #1;
      check("undefined cmd", {3'h0, mode}, {3'h0, pmrc_pkg::ST_ON});
      // Every command from ON, aux kept only in OFF
      for (int i = 0; i < 3; i++) begin
         host.write_cmd(codes[i]);
         wait_mode(modes[i]);
         check("aux", {7'h0, aux_en}, {7'h0, i == 0});
         wake();
      end
      // Aux in OFF: kept when it was on, dropped otherwise
      @(posedge mclk) seq_sel <= 1'b0;
      aux_req <= 1'b1;
      host.write_cmd(pmrc_pkg::CMD_GO_OFF);
      wait_mode(pmrc_pkg::ST_OFF);
      check("aux kept", {7'h0, aux_en}, 8'h01);
      @(posedge mclk) aux_req <= 1'b0;
      wake();
      host.write_cmd(pmrc_pkg::CMD_GO_OFF);
      wait_mode(pmrc_pkg::ST_OFF);
      check("aux dropped", {7'h0, aux_en}, 8'h00);
      // Commands outside ON are refused
      host.write_cmd(pmrc_pkg::CMD_GO_SEAL);
      repeat (3) @(posedge mclk);
      #1;
      check("cmd outside on", {3'h0, mode}, {3'h0, pmrc_pkg::ST_OFF});
      wake();
      // Internal condition shuts down
      @(posedge mclk) int_off <= 1'b1;
      wait_mode(pmrc_pkg::ST_OFF);
      @(posedge mclk) int_off <= 1'b0;
      wake();
      // Key active high: press off, release, press on
      host.set_pins(1'b1, 1'b1);
      wait_mode(pmrc_pkg::ST_OFF);
      host.set_pins(1'b0, 1'b1);
      repeat (20) @(posedge mclk);
      host.set_pins(1'b1, 1'b1);
      wait_mode(pmrc_pkg::ST_ON);
      host.set_pins(1'b0, 1'b1);
      repeat (20) @(posedge mclk);
      // Soft reset on pin B low, restore requested and then not
      for (int r = 1; r >= 0; r--) begin
         @(posedge mclk) restore_sel <= r[0];
         host.set_pins(1'b0, 1'b0);
         n = 0;
         while (rst_n !== 1'b0) step();
         check("restore", {7'h0, restore}, {7'h0, r[0]});
         n = 0;
         while (rst_n !== 1'b1) step();
         check("reset low cycles", n[7:0], SRST[7:0]);
         host.set_pins(1'b0, 1'b1);
         repeat (20) @(posedge mclk);
      end
      // Key active low, recovery chosen by the boot select
      @(posedge mclk) cfg <= pmrc_pkg::CFG_KEY_LOW;
      boot_sel <= 1'b1;
      host.set_pins(1'b1, 1'b1);
      repeat (20) @(posedge mclk);
      host.set_pins(1'b0, 1'b1);
      wait_mode(pmrc_pkg::ST_RECOV);
      wake();
      // Always-on: edge on A gives a delayed hard reset
      @(posedge mclk) cfg <= pmrc_pkg::CFG_ALWAYS_ON;
      repeat (20) @(posedge mclk);
      host.set_pins(1'b1, 1'b1);
      n = 0;
      while (por !== 1'b1) step();
      check("hard reset delay", {7'h0, n >= 41 && n <= 45}, 8'h01);
      check("boot", {3'h0, mode}, {3'h0, pmrc_pkg::ST_BOOT});
      wait_mode(pmrc_pkg::ST_RECOV);
      wake();
      // Always-on: edge on B gives a delayed soft reset, mode kept
      host.set_pins(1'b1, 1'b0);
      repeat (4) @(posedge mclk);
      host.set_pins(1'b1, 1'b1);
      n = 0;
      while (rst_n !== 1'b0) step();
      check("soft reset delay", {7'h0, n >= 41 && n <= 45}, 8'h01);
      check("still on", {3'h0, mode}, {3'h0, pmrc_pkg::ST_ON});
      summarize();
   end
endmodule // pmrc_power_mode_reset_control_tb_top
`default_nettype wire
